// ### include/sem_ctrl_defs.svh
// timing counts and field positions for the semaphore port controller
`ifndef SEM_CTRL_DEFS_SVH
`define SEM_CTRL_DEFS_SVH
`define CLK_PERIOD_NS    100
`define ADDR_SETUP_NS    200
`define ADDR_SETUP_CYC   ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS        100
`define STROBE_CYC       ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEM_COUNT        8
`define SEM_IDX_W        3
`define ADDR_W           14
`define DATA_W           9
`define FREE_BIT         0
`endif

// ### include/sem_ctrl_pkg.sv
// types shared by the semaphore port controller
package sem_ctrl_pkg;
  // user command codes
  typedef enum logic [1:0] {
    CMD_ACQUIRE = 2'h0,
    CMD_RELEASE = 2'h1,
    CMD_POLL    = 2'h2,
    CMD_INIT    = 2'h3
  } cmd_e;
  // pins that the controller drives toward one device port
  typedef struct packed {
    logic        sem_sel_n;
    logic        port_sel_n;
    logic        oe_n;
    logic        rw_n;
    logic [13:0] addr;
  } port_ctl_s;
  // controller states, gray along the usual path from ST_IDLE to ST_DONE
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_WRITE = 3'h3,
    ST_GAP   = 3'h2,
    ST_READ  = 3'h6,
    ST_DONE  = 3'h7
  } state_e;
endpackage

// ### rtl/sem_port_ctrl.sv
// host-side controller driving one port's semaphore space
// Operation
// R1: device busy pin direction follows master select
// R2: slave busy input inhibits that port's writes
// R3: master busy ignores read or write
// R4: address stable before write pulse starts
// R5: only one master in width array
// R6: eight semaphore latches separate from array
// R7: semaphore access uses select, enable, rw
// R8: flag index is low three address bits
// R9: only data bit zero written
// R10: write zero requests, one releases
// R11: writer sees zero, other port one
// R12: holder writing one frees semaphore
// R13: non-holder zero waits in request latch
// R14: read replicates flag on all bits
// R15: read latched while select and enable active
// R16: drop select or enable between polls
// R17: acquire writes zero then reads back
// R18: both selects high means standby
// R19: semaphore never gates array access
// R20: pending request takes token on release
// R21: simultaneous requests get exactly one winner
// R22: software writes one to all at power-up
// R23: two request latches feed one flag
// R24: no wait states on semaphore access
`include "sem_ctrl_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sem_port_ctrl
  import sem_ctrl_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  cmd_valid_i,
  input  wire logic [1:0]            cmd_op_i,
  input  wire logic [`SEM_IDX_W-1:0] cmd_idx_i,
  output logic                       cmd_ready_o,
  output logic                       done_o,
  output logic                       granted_o,
  output logic [`DATA_W-1:0]         rd_data_o,
  output logic                       sem_sel_n_o,
  output logic                       port_sel_n_o,
  output logic                       oe_n_o,
  output logic                       rw_n_o,
  output logic [`ADDR_W-1:0]         addr_o,
  output logic [`DATA_W-1:0]         dq_o,
  output logic                       dq_oe_o,
  input  wire logic [`DATA_W-1:0]    dq_i
);
  state_e                   state_q, state_d;  // sequencer state
  cmd_e                     op_q;              // command being run
  logic [`SEM_IDX_W-1:0]    idx_q;             // flag being worked
  logic [`SEM_IDX_W-1:0]    init_cnt_q;        // sweep for init
  logic [3:0]               cnt_q;             // phase counter
  logic                     wr_val_q;          // bit zero to write
  logic                     granted_q;         // last acquire or poll result; release clears it
  logic                     done_q;            // one-cycle completion
  logic [`DATA_W-1:0]       rd_q;              // captured read data
  logic [`DATA_W-1:0]       dq_s1_q, dq_s2_q;  // pin synchroniser
  port_ctl_s                pins_q;            // registered pin drive
  logic                     dq_oe_q;           // data driven
  wire  logic [3:0]         setup_len = 4'(`ADDR_SETUP_CYC);
  wire  logic [3:0]         strobe_len = 4'(`STROBE_CYC);
  wire  logic               phase_end;
  wire  logic               has_write;
  wire  logic               has_read;
  wire  logic               more_init;
  wire  logic               hold_zero;
  wire  logic               init_next_op;      // next access is a sweep
  wire  logic [`SEM_IDX_W-1:0] init_next;      // sweep index for next access
  wire  logic [`SEM_IDX_W-1:0] idx_next;       // index the pins will carry

  // compare counter against the length of the current phase
  assign phase_end = (state_q == ST_SETUP) ? (cnt_q + 4'h1 >= setup_len)
                                           : (cnt_q + 4'h1 >= strobe_len);
  assign has_write = (op_q != CMD_POLL);
  assign has_read  = (op_q == CMD_ACQUIRE) || (op_q == CMD_POLL);
  assign more_init = (op_q == CMD_INIT) && (init_cnt_q != 3'h7);
  // held token reads as all zeros; one zero bit is enough (see R14)
  assign hold_zero = ~dq_s2_q[`FREE_BIT];
  assign cmd_ready_o = (state_q == ST_IDLE);
  // address follows the command being started, so it never moves while
  // the select is already low for the new access
  assign init_next_op = (state_q == ST_IDLE) ? (cmd_op_i == 2'(CMD_INIT))
                                             : (op_q == CMD_INIT);
  assign init_next = (state_q == ST_IDLE) ? 3'h0
                   : (state_q == ST_GAP && state_d == ST_SETUP)
                     ? init_cnt_q + 3'h1 : init_cnt_q;
  assign idx_next = init_next_op ? init_next
                  : (state_q == ST_IDLE) ? cmd_idx_i : idx_q;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (cmd_valid_i) state_d = ST_SETUP;
      ST_SETUP: if (phase_end) state_d = has_write ? ST_WRITE : ST_GAP;
      ST_WRITE: if (phase_end) state_d = ST_GAP;
      // gap drops select so the read latch refreshes (see R16)
      ST_GAP: begin
        if (phase_end) begin
          if (has_read) state_d = ST_READ;
          else if (more_init) state_d = ST_SETUP;
          else state_d = ST_DONE;
        end
      end
      // hold three cycles past the strobe length so synchronised data is valid
      ST_READ:  if (cnt_q == strobe_len + 4'h2) state_d = ST_DONE;
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // state, counters and command capture
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q    <= ST_IDLE;
      op_q       <= CMD_POLL;
      idx_q      <= 3'h0;
      init_cnt_q <= 3'h0;
      cnt_q      <= 4'h0;
      wr_val_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 4'h0 : cnt_q + 4'h1;
      if (state_q == ST_IDLE && cmd_valid_i) begin
        op_q       <= cmd_e'(cmd_op_i);
        idx_q      <= cmd_idx_i;
        init_cnt_q <= 3'h0;
        // acquire writes zero first, then reads back (see R17, R10)
        wr_val_q   <= (cmd_op_i != 2'(CMD_ACQUIRE));
      end else if (state_q == ST_GAP && state_d == ST_SETUP) begin
        // init sweeps all eight flags writing one (see R22)
        init_cnt_q <= init_cnt_q + 3'h1;
      end
    end
  end

  // pin drive: address settles in setup before write strobe (see R4)
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pins_q  <= '{sem_sel_n: 1'b1, port_sel_n: 1'b1, oe_n: 1'b1,
                   rw_n: 1'b1, addr: 14'h0};
      dq_oe_q <= 1'b0;
    end else begin
      // array select stays high: semaphore space only (see R7, R18)
      // no array access, so no busy decision is asked of any master;
      // a wider array still needs exactly one master (see R5)
      pins_q.port_sel_n <= 1'b1;
      pins_q.addr <= {11'h0, idx_next};
      pins_q.sem_sel_n <= !(state_d == ST_SETUP || state_d == ST_WRITE
                            || state_d == ST_READ);
      pins_q.rw_n  <= !(state_d == ST_WRITE);
      pins_q.oe_n  <= !(state_d == ST_READ);
      dq_oe_q      <= (state_d == ST_WRITE) || (state_d == ST_SETUP
                       && has_write && state_q != ST_IDLE);
    end
  end

  // read data crosses from pins through two flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dq_s1_q <= 9'h0;
      dq_s2_q <= 9'h0;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // result capture at the end of the read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_q      <= 9'h1ff;
      granted_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= (state_q == ST_DONE);
      if (state_q == ST_READ && state_d == ST_DONE) begin
        rd_q      <= dq_s2_q;
        granted_q <= hold_zero; // zero back means token held (see R17)
      end else if (state_q == ST_DONE && op_q == CMD_RELEASE) begin
        granted_q <= 1'b0;
      end
    end
  end

  assign sem_sel_n_o  = pins_q.sem_sel_n;
  assign port_sel_n_o = pins_q.port_sel_n;
  assign oe_n_o       = pins_q.oe_n;
  assign rw_n_o       = pins_q.rw_n;
  assign addr_o       = pins_q.addr;
  // only bit zero matters on write; others follow it (see R9)
  assign dq_o         = {`DATA_W{wr_val_q}};
  assign dq_oe_o      = dq_oe_q;
  assign done_o       = done_q;
  assign granted_o    = granted_q;
  assign rd_data_o    = rd_q;

  // strobes never overlap: oe and write not low together
  chk_no_overlap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(!oe_n_o && !rw_n_o)) else $error("oe and write low together"); // see R7
  // write strobe only inside semaphore select, array deselected
  chk_write_sem: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rw_n_o |-> !sem_sel_n_o && port_sel_n_o && dq_oe_o)
    else $error("write outside semaphore select"); // see R18
  // address stable the cycle before and during write start
  chk_addr_setup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(rw_n_o) |-> $stable(addr_o) && !$past(sem_sel_n_o))
    else $error("address not settled before write"); // see R4
  // high address bits stay zero
  chk_addr_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    addr_o[13:3] == 11'h0) else $error("upper address bits set"); // see R8
  // a new read is preceded by select and enable both high
  sequence read_start;
    $fell(oe_n_o);
  endsequence
  chk_poll_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    read_start |-> $past(oe_n_o) && $past(sem_sel_n_o))
    else $error("read without deselect"); // see R16
  // acquire write data is zero on bit zero
  chk_acq_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!rw_n_o && op_q == CMD_ACQUIRE) |-> dq_o[0] == 1'b0)
    else $error("acquire did not write zero"); // see R10
  // done lasts a single cycle
  chk_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o |=> !done_o) else $error("done longer than a cycle"); // see R17
  // grant reflects bit zero of the captured read
  chk_grant_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(done_o) && op_q != CMD_RELEASE && op_q != CMD_INIT
    |-> granted_o == !rd_data_o[0])
    else $error("grant disagrees with data"); // see R14
endmodule
`default_nettype wire

// ### test/sem_dev_model.sv
// behavioural model of the device semaphore space
`timescale 1ns/1ps
`default_nettype none
module sem_dev_model (
  input  wire logic        sem_sel_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        rw_n_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [8:0]  dq_i,
  input  wire logic        dq_oe_i,
  output logic      [8:0]  dq_o,
  input  wire logic        port_sel_n_i,
  input  wire logic        ms_i,
  input  wire logic        r_arr_i,
  output logic             busy_n_o,
  input  wire logic        r_wr_i,
  input  wire logic [2:0]  r_idx_i,
  input  wire logic        r_d0_i,
  output logic      [7:0]  own_r_o
);
  // junk power-up state: left holds all eight until init frees them
  logic [7:0] rq_l = 8'h00;  // request latches
  logic [7:0] rq_r = 8'hff;
  logic [7:0] own_l = 8'hff; // flag sides
  logic [7:0] own_r = 8'h00;
  logic [8:0] rd_q = 9'h1ff; // latched read word
  wire        rd_n = sem_sel_n_i | oe_n_i;
  // drop a released owner, then hand the flag to a pending side
  task automatic settle(input int i);
    if (own_l[i] && rq_l[i]) own_l[i] = 1'b0;
    if (own_r[i] && rq_r[i]) own_r[i] = 1'b0;
    if (!own_l[i] && !own_r[i]) begin
      if (!rq_l[i]) own_l[i] = 1'b1; // a tie goes left
      else if (!rq_r[i]) own_r[i] = 1'b1;
    end
  endtask
  // left write: low index bits and bit zero only, no wait state
  always @(negedge rw_n_i) begin
    if (!sem_sel_n_i) begin
      // an undriven bus reads as the inverse, so a lost enable shows
      rq_l[addr_i[2:0]] = dq_oe_i ? dq_i[0] : ~dq_i[0];
      settle(int'(addr_i[2:0]));
    end
  end
  // right-port write made by the bench
  always @(posedge r_wr_i) begin
    rq_r[r_idx_i] = r_d0_i;
    settle(int'(r_idx_i));
  end
  // flag spread on all bits, frozen while selected and enabled
  always @(negedge rd_n) rd_q = {9{~own_l[addr_i[2:0]]}};
  // a released bus shows the inverse so stale data never matches
  assign dq_o = rd_n ? ~rd_q : rd_q;
  assign own_r_o = own_r; // flags gate nothing else
  // master flags busy from selects alone, read or write alike; the right
  // side is taken to sit on the same array address
  // a slave drives no busy; its pin would only inhibit array writes,
  // and this port never writes the array
  assign busy_n_o = !(ms_i && !port_sel_n_i && r_arr_i);
endmodule
`default_nettype wire

// ### test/sem_port_ctrl_tb.sv
// self-checking bench for the semaphore port controller
`timescale 1ns/1ps
`default_nettype none
module sem_port_ctrl_tb;
  import sem_ctrl_pkg::*;
  typedef struct packed {
    cmd_e       op;
    logic [2:0] idx;
    logic       gnt;
  } row_s;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic [1:0]  cmd_op_i = 2'h0;
  logic [2:0]  cmd_idx_i = 3'h0;
  logic [2:0]  r_idx = 3'h0;
  logic        r_wr = 1'b0;
  logic        r_d0 = 1'b1;
  logic        cmd_ready_o, done_o, granted_o, sem_sel_n_o;
  logic        port_sel_n_o, oe_n_o, rw_n_o, dq_oe_o;
  logic [8:0]  rd_data_o, dq_o, dq_i;
  logic [13:0] addr_o;
  logic [7:0]  own_r;
  logic        r_arr = 1'b0;  // right port reading the array
  logic        busy_n;        // busy seen by this port
  int          n_mismatch = 0;
  int          tests_run = 0;
  // ordinary commands with the grant each should leave
  row_s rows [6] = '{'{CMD_ACQUIRE, 3'h0, 1'b1}, '{CMD_RELEASE, 3'h0, 1'b0},
    '{CMD_ACQUIRE, 3'h7, 1'b1}, '{CMD_POLL, 3'h7, 1'b1},
    '{CMD_RELEASE, 3'h7, 1'b0}, '{CMD_ACQUIRE, 3'h5, 1'b1}};
  always #50 clk_i = ~clk_i;
  sem_port_ctrl i_dut (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_op_i,
    .cmd_idx_i, .cmd_ready_o, .done_o, .granted_o, .rd_data_o,
    .sem_sel_n_o, .port_sel_n_o, .oe_n_o, .rw_n_o, .addr_o, .dq_o,
    .dq_oe_o, .dq_i);
  sem_dev_model i_dev (.sem_sel_n_i(sem_sel_n_o), .oe_n_i(oe_n_o),
    .rw_n_i(rw_n_o), .addr_i(addr_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o),
    .dq_o(dq_i), .port_sel_n_i(port_sel_n_o), .ms_i(1'b1),
    .r_arr_i(r_arr), .busy_n_o(busy_n),
    .r_wr_i(r_wr), .r_idx_i(r_idx), .r_d0_i(r_d0), .own_r_o(own_r));
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic chk9(input logic [8:0] g, input logic [8:0] e,
                      input string m);
    chk1(g === e, 1'b1, m);
  endtask
  // bounded wait for ready (0) or done (1), sampled just after each edge
  task automatic wait_hi(input bit on_done);
    int n = 0;
    while ((on_done ? done_o : cmd_ready_o) !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #5 n++;
    end
    chk1(n < 100, 1'b1, "handshake timeout");
  endtask
  task automatic run(input cmd_e op, input logic [2:0] idx);
    wait_hi(1'b0);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_idx_i = idx;
    @(posedge clk_i);
    #5 cmd_valid_i = 1'b0;
    wait_hi(1'b1);
  endtask
  // far-side processor writes one flag, on the bench's usual offset
  task automatic rwr(input logic [2:0] i, input logic d);
    @(posedge clk_i);
    #5 r_idx = i;
    r_d0 = d;
    r_wr = 1'b1;
    @(posedge clk_i);
    #5 r_wr = 1'b0;
  endtask
  initial begin
    #200000 n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #5 chk9(rd_data_o, 9'h1ff, "reset word");
    chk1(sem_sel_n_o & oe_n_o & rw_n_o & ~dq_oe_o, 1'b1, "idle");
    rst_n_i = 1'b1;
    run(CMD_INIT, 3'h0);
    for (int i = 0; i < 8; i++) begin
      rwr(3'(i), 1'b0);
      chk1(own_r[i], 1'b1, "flag not freed");
      rwr(3'(i), 1'b1);
    end
    foreach (rows[k]) begin
      run(rows[k].op, rows[k].idx);
      chk1(granted_o, rows[k].gnt, "grant");
      if (rows[k].op != CMD_RELEASE)
        chk9(rd_data_o, {9{~rows[k].gnt}}, "word");
    end
    // far side shut out of flag 5 while this port holds it
    rwr(3'h5, 1'b0);
    chk1(own_r[5], 1'b0, "far side took held flag");
    rwr(3'h5, 1'b1);
    // reset in mid-command: pins fall back to idle, results clear
    cmd_valid_i = 1'b1;
    cmd_op_i = CMD_ACQUIRE;
    cmd_idx_i = 3'h2;
    @(posedge clk_i);
    #5 cmd_valid_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #5 chk1(sem_sel_n_o & oe_n_o & rw_n_o & ~dq_oe_o, 1'b1, "rst");
    chk1(granted_o, 1'b0, "reset grant");
    chk9(rd_data_o, 9'h1ff, "mid reset word");
    rst_n_i = 1'b1;
    // far side holds 3, then hands it over on release
    rwr(3'h3, 1'b0);
    run(CMD_ACQUIRE, 3'h3);
    chk1(granted_o, 1'b0, "held elsewhere");
    chk9(rd_data_o, 9'h1ff, "busy word");
    rwr(3'h3, 1'b1);
    chk1(own_r[3], 1'b0, "far side kept it");
    r_arr = 1'b1;
    run(CMD_POLL, 3'h3);
    chk1(granted_o, 1'b1, "poll stale");
    chk1(busy_n, 1'b1, "busy raised");
    r_arr = 1'b0;
    run(CMD_RELEASE, 3'h3);
    rwr(3'h3, 1'b0);
    chk1(own_r[3], 1'b1, "not freed");
    chk1(port_sel_n_o, 1'b1, "array selected");
    complete_run();
  end
endmodule
`default_nettype wire
